// file: include/pcirq_params.svh
`ifndef PCIRQ_PARAMS_SVH
`define PCIRQ_PARAMS_SVH
// byte addresses of the register map
`define PCIRQ_B_RISE 8'h00
`define PCIRQ_B_FALL 8'h04
`define PCIRQ_B_FLAG 8'h08
`define PCIRQ_C_RISE 8'h0c
`define PCIRQ_C_FALL 8'h10
`define PCIRQ_C_FLAG 8'h14
`define PCIRQ_E_RISE 8'h18
`define PCIRQ_E_FALL 8'h1c
`define PCIRQ_E_FLAG 8'h20
`define PCIRQ_G_RISE 8'h24
`define PCIRQ_G_FALL 8'h28
`define PCIRQ_G_FLAG 8'h2c
`define PCIRQ_CTRL 8'h30
`define PCIRQ_STATUS 8'h34
// field positions and masks
`define PCIRQ_G_PIN 5
`define PCIRQ_G_MASK 8'h20
`define PCIRQ_CTRL_IRQ_EN 0
`define PCIRQ_STAT_SHARED 0
`define PCIRQ_RESET_VAL 8'h00
`define PCIRQ_RESP_OKAY 2'b00
`define PCIRQ_RESP_SLVERR 2'b10
`endif

// file: include/pcirq_pkg.sv
package pcirq_pkg;
	typedef struct packed {
		logic [7:0] rise;
		logic [7:0] fall;
		logic [7:0] flag;
	} pcirq_port_t;
	typedef struct packed {
		logic [7:0] b;
		logic [7:0] c;
		logic [7:0] e;
		logic [7:0] g;
	} pcirq_pins_t;
	typedef enum logic [1:0] {
		PCIRQ_PB = 2'b00,
		PCIRQ_PC = 2'b01,
		PCIRQ_PE = 2'b10,
		PCIRQ_PG = 2'b11
	} pcirq_port_sel_t;
endpackage

// file: hw/pcirq_top.sv
// Purpose: pin edge-change detector for ports b, c, e and g with axi4-lite registers
// Assumes: pins synchronous to aclk; single clock, synchronous active-low reset
// Notes: flag writes of zero clear, ones leave the flag alone; hardware set wins
//
// Summary of operation
// - rise enable set: low-to-high pin edge sets its flag and shared flag; port g pin 5 only.
// - fall enable set: high-to-low edge sets flag and shared flag; disabled polarity ignored.
// - flag sets only on an enabled-polarity edge; rise and fall qualified independently.
// - flags readable, hardware sets, software clears by writing zero.
// - reset-pin or low-voltage-program enable high disables port g pin 5 detection.
// - port g bits 7-6 and 4-0 read zero and ignore writes.
// - all enable and flag bits reset to zero.
// - ports b, c and e have eight rise, fall and flag bits each.
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`include "pcirq_params.svh"
module pcirq_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] port_b_pins,
	input wire logic [7:0] port_c_pins,
	input wire logic [7:0] port_e_pins,
	input wire logic port_g_pin_five,
	input wire logic master_reset_pin_enable,
	input wire logic low_voltage_program_enable,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq
);
	pcirq_pkg::pcirq_port_t port_q [4];
	pcirq_pkg::pcirq_port_t port_d [4];
	pcirq_pkg::pcirq_pins_t pins_now;
	pcirq_pkg::pcirq_pins_t pins_q;
	pcirq_pkg::pcirq_pins_t pins_d;
	logic [7:0] impl_mask [4];
	logic irq_en_q;
	logic irq_en_d;
	logic irq_q;
	logic irq_d;
	logic shared_change_irq_flag;
	logic g_disabled;
	// write channel state
	logic aw_have_q;
	logic aw_have_d;
	logic w_have_q;
	logic w_have_d;
	logic [7:0] aw_addr_q;
	logic [7:0] aw_addr_d;
	logic [31:0] w_data_q;
	logic [31:0] w_data_d;
	logic [3:0] w_strb_q;
	logic [3:0] w_strb_d;
	logic bvalid_q;
	logic bvalid_d;
	logic [1:0] bresp_q;
	logic [1:0] bresp_d;
	// read channel state
	logic rvalid_q;
	logic rvalid_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0] rresp_q;
	logic [1:0] rresp_d;
	logic do_write;
	logic do_read;
	// ready lines registered so every port comes straight off a flop
	logic awready_q;
	logic awready_d;
	logic wready_q;
	logic wready_d;
	logic arready_q;
	logic arready_d;

	assign g_disabled = master_reset_pin_enable | low_voltage_program_enable;
	assign impl_mask[0] = 8'hff;
	assign impl_mask[1] = 8'hff;
	assign impl_mask[2] = 8'hff;
	assign impl_mask[3] = `PCIRQ_G_MASK;
	assign pins_now.b = port_b_pins;
	assign pins_now.c = port_c_pins;
	assign pins_now.e = port_e_pins;
	// disabled g pin is frozen low in the history too, so re-enabling while the pin is high looks like a rise
	assign pins_now.g = {2'b00, port_g_pin_five & ~g_disabled, 5'b00000};

	assign do_write = aw_have_q & w_have_q & ~bvalid_q;
	assign do_read = s_axi_arvalid & ~rvalid_q;

	always_comb
	begin
		logic [7:0] cur;
		logic [7:0] prv;
		logic [7:0] hit;
		logic [7:0] wv;
		logic any;
		cur = 8'h00;
		prv = 8'h00;
		hit = 8'h00;
		wv = 8'h00;
		any = 1'b0;
		pins_d = pins_now;
		irq_en_d = irq_en_q;
		for (int i = 0; i < 4; i++)
		begin
			port_d[i] = port_q[i];
			cur = pins_now[8*(3-i) +: 8];
			prv = pins_q[8*(3-i) +: 8];
			// rise and fall qualified separately; masked pins never hit
			hit = ((cur & ~prv & port_q[i].rise) | (~cur & prv & port_q[i].fall)) & impl_mask[i];
			if (i == 3 && g_disabled)
			begin
				hit = 8'h00;
			end
			wv = w_data_q[7:0] & impl_mask[i];
			if (do_write && w_strb_q[0])
			begin
				if (aw_addr_q == `PCIRQ_B_RISE + 8'(12 * i))
				begin
					port_d[i].rise = wv;
				end
				if (aw_addr_q == `PCIRQ_B_FALL + 8'(12 * i))
				begin
					port_d[i].fall = wv;
				end
				if (aw_addr_q == `PCIRQ_B_FLAG + 8'(12 * i))
				begin
					// zero clears, one keeps
					port_d[i].flag = port_q[i].flag & (wv | ~impl_mask[i]);
				end
			end
			// set after clear so an edge in the clearing cycle survives
			port_d[i].flag = (port_d[i].flag | hit) & impl_mask[i];
			any = any | (|port_q[i].flag);
		end
		if (do_write && w_strb_q[0] && aw_addr_q == `PCIRQ_CTRL)
		begin
			irq_en_d = w_data_q[`PCIRQ_CTRL_IRQ_EN];
		end
		shared_change_irq_flag = any;
		irq_d = any & irq_en_q;
	end

	always_comb
	begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		aw_addr_d = aw_addr_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		if (s_axi_awvalid && !aw_have_q)
		begin
			aw_have_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_have_q)
		begin
			w_have_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (do_write)
		begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			// status, unmapped and misaligned words refuse writes
			if (aw_addr_q[1:0] == 2'b00 && aw_addr_q <= `PCIRQ_CTRL)
			begin
				bresp_d = `PCIRQ_RESP_OKAY;
			end
			else
			begin
				bresp_d = `PCIRQ_RESP_SLVERR;
			end
		end
		else if (bvalid_q && s_axi_bready)
		begin
			bvalid_d = 1'b0;
		end
		awready_d = ~aw_have_d;
		wready_d = ~w_have_d;
	end

	always_comb
	begin
		logic [7:0] v;
		v = 8'h00;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (do_read)
		begin
			rvalid_d = 1'b1;
			rresp_d = `PCIRQ_RESP_OKAY;
			unique case (s_axi_araddr)
				`PCIRQ_B_RISE: v = port_q[0].rise;
				`PCIRQ_B_FALL: v = port_q[0].fall;
				`PCIRQ_B_FLAG: v = port_q[0].flag;
				`PCIRQ_C_RISE: v = port_q[1].rise;
				`PCIRQ_C_FALL: v = port_q[1].fall;
				`PCIRQ_C_FLAG: v = port_q[1].flag;
				`PCIRQ_E_RISE: v = port_q[2].rise;
				`PCIRQ_E_FALL: v = port_q[2].fall;
				`PCIRQ_E_FLAG: v = port_q[2].flag;
				`PCIRQ_G_RISE: v = port_q[3].rise;
				`PCIRQ_G_FALL: v = port_q[3].fall;
				`PCIRQ_G_FLAG: v = port_q[3].flag;
				`PCIRQ_CTRL: v = {7'h00, irq_en_q};
				`PCIRQ_STATUS: v = {7'h00, shared_change_irq_flag};
				default:
				begin
					v = 8'h00;
					rresp_d = `PCIRQ_RESP_SLVERR;
				end
			endcase
			rdata_d = {24'h000000, v};
		end
		else if (rvalid_q && s_axi_rready)
		begin
			rvalid_d = 1'b0;
		end
		arready_d = ~rvalid_d;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 4; i++)
			begin
				port_q[i] <= '0;
			end
			pins_q <= '0;
			irq_en_q <= 1'b0;
			irq_q <= 1'b0;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'b00;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= 2'b00;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			arready_q <= 1'b1;
		end
		else
		begin
			// first cycle after reset compares against zeros: a high pin looks like a rise
			for (int i = 0; i < 4; i++)
			begin
				port_q[i] <= port_d[i];
			end
			pins_q <= pins_d;
			irq_en_q <= irq_en_d;
			irq_q <= irq_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			aw_addr_q <= aw_addr_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			arready_q <= arready_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign irq = irq_q;
endmodule

// file: testbench/pcirq_pins_model.sv
// Purpose: far-side pin drivers
// Assumes: bench asks for levels, pins follow one edge later
// Notes: push-pull pins, always at a level
module pcirq_pins_model (
	input wire logic aclk,
	input wire logic [24:0] want,
	output logic [24:0] pins
);
	timeunit 1ns;
	timeprecision 100ps;
	initial pins = '0;
	always @(posedge aclk) pins <= want;
endmodule

// file: testbench/pcirq_top_assertions.sv
// Purpose: bus and irq relations at the top ports
// Assumes: one clock, synchronous active-low reset
// Notes: flag contents are judged by the bench
module pcirq_top_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic irq,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_IRQ_RESET: assert property ($rose(aresetn) |-> !irq) else $error("irq high after reset");
	AST_IRQ_FALL: assert property ($fell(irq) |-> $past(s_axi_bvalid)) else $error("irq fell without write");
	AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper data set");
	AST_AR_BLOCKED: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready while rvalid");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late rvalid");
	AST_B_HOLD: assert property (s_axi_bvalid |=> s_axi_bvalid != $past(s_axi_bready)) else $error("bvalid hold");
	AST_R_HOLD: assert property (s_axi_rvalid |=> s_axi_rvalid != $past(s_axi_rready)) else $error("rvalid hold");
	AST_AW_TAKEN: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("awready stayed");
endmodule
bind pcirq_top pcirq_top_assertions chk_i (
	.aclk(aclk),
	.aresetn(aresetn),
	.irq(irq),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata)
);

// file: testbench/pin_edge_change_interrupt_bench.sv
// Purpose: self-checking bench for the pin change detector
// Assumes: every request is answered; a hang is ended by the watchdog
// Notes: ready raised late on purpose to hold responses
`include "pcirq_params.svh"
module pin_edge_change_interrupt_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk, aresetn, master_reset_pin_enable, low_voltage_program_enable, port_g_pin_five, irq;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] port_b_pins, port_c_pins, port_e_pins, s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, rr;
	logic [24:0] want;
	logic [23:0] rows [9];
	int miscompares = 0;
	int check_count = 0;
	pcirq_top uut (
		.aclk(aclk),
		.aresetn(aresetn),
		.port_b_pins(port_b_pins),
		.port_c_pins(port_c_pins),
		.port_e_pins(port_e_pins),
		.port_g_pin_five(port_g_pin_five),
		.master_reset_pin_enable(master_reset_pin_enable),
		.low_voltage_program_enable(low_voltage_program_enable),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.irq(irq)
	);
	pcirq_pins_model pm (.aclk(aclk), .want(want), .pins({port_g_pin_five, port_e_pins, port_c_pins, port_b_pins}));
	initial
	begin
		aclk = 0;
		forever #12.5 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (n == 3) s_axi_bready <= 1;
		end
		while (!(s_axi_bvalid && s_axi_bready));
		r = s_axi_bresp;
		s_axi_bready <= 0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (n == 2) s_axi_rready <= 1;
		end
		while (!(s_axi_rvalid && s_axi_rready));
		d = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 0;
		@(posedge aclk);
	endtask
	// flag bytes packed {g, e, c, b}; flag registers sit 12 bytes apart
	task automatic flags(input logic [31:0] e);
		for (int k = 0; k < 4; k++)
		begin
			rd(`PCIRQ_B_FLAG + 8'(12 * k));
			chk(d, {24'h0, e[8 * k +: 8]});
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		#100us;
		miscompares++;
		complete_run;
	end
	initial
	begin
		{aresetn, master_reset_pin_enable, low_voltage_program_enable, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, want} = '0;
		s_axi_wstrb = 4'hf;
		rows = '{{`PCIRQ_B_RISE, 16'h0f0f}, {`PCIRQ_B_FALL, 16'hf0f0}, {`PCIRQ_C_RISE, 16'hffff},
			{`PCIRQ_E_FALL, 16'hffff}, {`PCIRQ_G_RISE, 16'hff20}, {`PCIRQ_G_FALL, 16'hdf00},
			{`PCIRQ_G_FLAG, 16'hff00}, {`PCIRQ_CTRL, 16'hff01}, {8'h38, 16'hff00}};
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		foreach (rows[i])
		begin
			rd(rows[i][23:16]);
			chk(d, 32'h0);
			wr(rows[i][23:16], rows[i][15:8]);
			chk(r, i == 8 ? `PCIRQ_RESP_SLVERR : `PCIRQ_RESP_OKAY);
			rd(rows[i][23:16]);
			chk(d, {24'h0, rows[i][7:0]});
			chk(rr, i == 8 ? `PCIRQ_RESP_SLVERR : `PCIRQ_RESP_OKAY);
		end
		// low byte lane off: the register must keep its value
		s_axi_wstrb <= 4'he;
		wr(`PCIRQ_B_RISE, 8'h55);
		chk(r, `PCIRQ_RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rd(`PCIRQ_B_RISE);
		chk(d, 32'h0f);
		want <= '1;
		repeat (6) @(posedge aclk);
		chk(irq, 1'b1);
		flags(32'h2000ff0f);
		want <= '0;
		repeat (6) @(posedge aclk);
		flags(32'h20ffffff);
		rd(`PCIRQ_STATUS);
		chk(d, 32'h1);
		wr(`PCIRQ_CTRL, 8'h00);
		chk(irq, 1'b0);
		wr(`PCIRQ_CTRL, 8'h01);
		chk(irq, 1'b1);
		for (int k = 0; k < 4; k++) wr(`PCIRQ_B_FLAG + 8'(12 * k), 8'h00);
		flags(32'h0);
		chk(irq, 1'b0);
		for (int k = 1; k < 3; k++)
		begin
			{master_reset_pin_enable, low_voltage_program_enable} <= 2'(k);
			want <= 25'h1000000;
			repeat (6) @(posedge aclk);
			want <= '0;
			repeat (6) @(posedge aclk);
			flags(32'h0);
		end
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(`PCIRQ_B_RISE);
		chk(d, 32'h0);
		rd(`PCIRQ_CTRL);
		chk(d, 32'h0);
		complete_run;
	end
endmodule
